// File: hw/io_wake_bank.v
/*
 Pin wake and interrupt configuration bank reached over a 16-bit SPI frame.
 Assumes an SPI master in mode 0 (sample on rising sck, shift on falling),
 MSB first, cs_n framing, sck slower than clk / 8 (160 ns in the bench).
 Pins, straps, sck, mosi and cs_n are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`include "io_wake_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - wake field 00 off, 01 rising, 10 falling, 11 either edge
// - six wake fields; register A pins 0-2, B pins 3-5, bits 7..2
// - pin 0 and pin 1 inhibit bits mask interrupt and group flag
// - register B bit1 masks pins 2-3, bit0 masks pins 4-5
// - duration bit: 0 gives 100 us pulse, 1 gives 25 us
// - global inhibit plus per-source inhibits for five regulator/CAN sources
// - pre-regulator inhibit blocks only pre-regulator status change interrupts
// - topology bit: 0 buck-boost, 1 buck only
// - aux unused bit: 0 aux present and switchable, 1 unused
// - pass device bit: 0 external transistor, 1 internal
// - ref strap 0=3.3V 1=5.0V; aux strap 0=5.0V 1=3.3V
// - debug bit: 0 normal, 1 debug mode selected
// - report bits sampled at reset and on leaving low-power off
// - per-pin wake flags set on wake event, clear on reset or read
// - bus wake flag in bit 0, set by CAN wake, cleared likewise
// - pin levels update in normal mode only, frozen in low-power off
// - level bits: pins 5,4 at 7,6; 3,2 at 4,3; 1,0 at 1,0
// - configuration registers writable only during initialisation phase
// - register address taken from frame bits 13 down to 9
// - second feedback monitoring removes pin 1 as wake source; its level still reads
module io_wake_bank (
  input wire clk, // 100 MHz system clock
  input wire srst, // synchronous reset, active high
  input wire sck, // SPI clock from host
  input wire cs_n, // SPI chip select, active low
  input wire mosi, // SPI data from host
  output reg miso, // SPI data to host
  output reg miso_oe, // miso drive enable, high while selected
  input wire [5:0] io_pin, // general I/O pin levels
  input wire bus_wake_evt, // CAN physical layer wake level/pulse
  input wire low_power_off_state, // device in low-power off state
  input wire init_phase, // initialisation window open
  input wire second_feedback_monitor_en, // pin 1 used for core feedback
  input wire [5:0] strap_in, // topology,aux_unused,pass,ref_v,aux_v,debug
  input wire sns_uv_evt, // battery sense undervoltage event
  input wire pre_evt, // pre-regulator status change
  input wire core_evt, // core regulator status change
  input wire others_evt, // other regulator status change
  input wire can_err_evt, // CAN error bits changed
  output reg int_n, // interrupt pulse, active low
  output reg io_group_flag, // unmasked pin wake pending
  output reg [5:0] wake_req // wake-up request per pin
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  // every foreign input passes two flops; this costs three clocks of
  // latency on the link, which the four-clock half period of sck absorbs
  wire [5:0] pin_s;
  wire [5:0] strap_s;
  wire [6:0] misc_s;

  pin_sync2 #(.W(6)) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async_in(io_pin),
    .sync_out(pin_s)
  );

  pin_sync2 #(.W(6)) u_strap_sync (
    .clk(clk),
    .srst(srst),
    .async_in(strap_in),
    .sync_out(strap_s)
  );

  pin_sync2 #(.W(7)) u_misc_sync (
    .clk(clk),
    .srst(srst),
    // select is carried inverted so that the cleared flops read as idle
    .async_in({sck, ~cs_n, mosi, bus_wake_evt, low_power_off_state, init_phase,
               second_feedback_monitor_en}),
    .sync_out(misc_s)
  );

  wire sck_s = misc_s[6];
  wire cs_n_s = ~misc_s[5];
  wire mosi_s = misc_s[4];
  wire bus_wake_s = misc_s[3];
  wire low_power_off_state_s = misc_s[2];
  wire init_s = misc_s[1];
  wire fb_mon_s = misc_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // edge helpers

  function edge_hit;
    input [1:0] mode;
    input now;
    input prev;
    begin
      case (mode)
        `EDGE_RISE: edge_hit = now & ~prev;
        `EDGE_FALL: edge_hit = ~now & prev;
        `EDGE_ANY: edge_hit = now ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg sck_prev_q;
  reg cs_prev_q;
  reg bus_wake_prev_q;
  reg low_power_off_state_prev_q;
  reg [5:0] pin_prev_q;

  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire cs_start = ~cs_n_s & cs_prev_q;
  wire cs_end = cs_n_s & ~cs_prev_q;

  always @(posedge clk) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bus_wake_prev_q <= 1'b0;
      low_power_off_state_prev_q <= 1'b0;
      pin_prev_q <= 6'h00;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
      bus_wake_prev_q <= bus_wake_s;
      low_power_off_state_prev_q <= low_power_off_state_s;
      pin_prev_q <= pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [7:0] wake_cfg_a_q;
  reg [7:0] wake_cfg_b_q;
  reg [7:0] int_cfg_q;
  reg [7:0] hw_report_q;
  reg [5:0] pin_wake_flag_q;
  reg bus_wake_flag_q;
  reg [5:0] level_q;
  reg [5:0] pin_inh;
  reg [11:0] edge_cfg;
  reg [5:0] wake_hit;
  integer i;

  always @* begin
    edge_cfg = {wake_cfg_b_q[3:2], wake_cfg_b_q[5:4], wake_cfg_b_q[7:6],
                wake_cfg_a_q[3:2], wake_cfg_a_q[5:4], wake_cfg_a_q[7:6]};
    pin_inh = {wake_cfg_b_q[0], wake_cfg_b_q[0], wake_cfg_b_q[1], wake_cfg_b_q[1],
               wake_cfg_a_q[1], wake_cfg_a_q[0]};
    for (i = 0; i < 6; i = i + 1) begin
      wake_hit[i] = edge_hit(edge_cfg[2*i +: 2], pin_s[i], pin_prev_q[i]);
    end
    if (fb_mon_s) begin
      wake_hit[1] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI frame engine
  // bits are taken on the synchronised rising sck and the answer shifts on
  // the falling one; a frame shorter than 16 bits commits nothing and clears
  // nothing, and bits past the 16th are ignored
  reg [4:0] bit_cnt_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [4:0] addr_q;
  reg clear_src_q;

  function [7:0] read_mux;
    input [4:0] a;
    begin
      case (a)
        `ADDR_WAKE_CFG_A: read_mux = wake_cfg_a_q;
        `ADDR_WAKE_CFG_B: read_mux = wake_cfg_b_q;
        `ADDR_INT_CFG: read_mux = int_cfg_q;
        `ADDR_HW_REPORT: read_mux = hw_report_q;
        `ADDR_WAKE_SRC: read_mux = {pin_wake_flag_q[5:0], 1'b0, bus_wake_flag_q};
        `ADDR_PIN_LEVELS: read_mux = {level_q[5:4], 1'b0, level_q[3:2], 1'b0,
                                      level_q[1:0]};
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // seven bits are in when the address is used, so it sits at the bottom
  wire [4:0] addr_now = rx_q[`FRM_ADDR_HI-`FRM_ADDR_LO:0];
  wire frame_done = cs_end & (bit_cnt_q == 5'h10);
  wire frame_wr = rx_q[`FRM_WRITE];
  wire [7:0] frame_data = rx_q[7:0];
  wire cfg_wr_ok = frame_done & frame_wr & init_s;

  always @(posedge clk) begin
    if (srst) begin
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      addr_q <= 5'h00;
      clear_src_q <= 1'b0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      clear_src_q <= 1'b0;
      miso_oe <= ~cs_n_s;
      if (cs_start) begin
        bit_cnt_q <= 5'h00;
        tx_q <= 16'h0000;
        miso <= 1'b0;
      end else if (!cs_n_s && sck_rise && bit_cnt_q != 5'h10) begin
        rx_q <= {rx_q[14:0], mosi_s};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        // data half of the answer is loaded once the address is known
        if (bit_cnt_q == 5'h07) begin
          addr_q <= addr_now;
          tx_q <= {8'h00, read_mux(addr_now)};
        end
      end else if (!cs_n_s && sck_fall) begin
        miso <= tx_q[7];
        tx_q <= {tx_q[14:0], 1'b0};
      end
      // flags cleared only once the full frame has shifted out
      if (frame_done && !frame_wr && addr_q == `ADDR_WAKE_SRC) begin
        clear_src_q <= 1'b1;
      end
    end
  end

  // flags shown in the answer; only these are cleared at frame end
  reg [6:0] src_snap_q;
  always @(posedge clk) begin
    if (srst) begin
      src_snap_q <= 7'h00;
    end else if (!cs_start && !cs_n_s && sck_rise && bit_cnt_q == 5'h07) begin
      src_snap_q <= {pin_wake_flag_q, bus_wake_flag_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register updates
  // writes land only at the end of a whole frame, so a cut frame is harmless
  always @(posedge clk) begin
    if (srst) begin
      wake_cfg_a_q <= `CFG_RESET;
      wake_cfg_b_q <= `CFG_RESET;
      int_cfg_q <= `CFG_RESET;
    end else if (cfg_wr_ok) begin
      case (addr_q)
        `ADDR_WAKE_CFG_A: wake_cfg_a_q <= frame_data;
        `ADDR_WAKE_CFG_B: wake_cfg_b_q <= frame_data;
        `ADDR_INT_CFG: int_cfg_q <= frame_data & `INT_CFG_MASK;
        default: ;
      endcase
    end
  end

  // straps caught on the third edge after reset and on leaving low-power off;
  // the synchroniser is cleared by reset, so earlier edges would see zeros
  reg [1:0] strap_wait_q;
  always @(posedge clk) begin
    if (srst) begin
      strap_wait_q <= 2'h0;
      hw_report_q <= 8'h00;
    end else begin
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
      if ((strap_wait_q == 2'h2) || (low_power_off_state_prev_q && !low_power_off_state_s)) begin
        hw_report_q <= {strap_s[5:1], 1'b1, 1'b0, strap_s[0]};
      end
    end
  end

  wire bus_hit = bus_wake_s & ~bus_wake_prev_q;
  // an event that came after the answer was taken survives the clear
  wire [6:0] src_clr = clear_src_q ? src_snap_q : 7'h00;

  always @(posedge clk) begin
    if (srst) begin
      pin_wake_flag_q <= 6'h00;
      bus_wake_flag_q <= 1'b0;
    end else begin
      // a new event wins over the read clear
      pin_wake_flag_q <= (pin_wake_flag_q & ~src_clr[6:1]) | wake_hit;
      bus_wake_flag_q <= (bus_wake_flag_q & ~src_clr[0]) | bus_hit;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      level_q <= 6'h00;
    end else if (!low_power_off_state_s) begin
      level_q <= pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources
  // wake_hit is a one-cycle strobe, so a held pin level fires only once;
  // the global inhibit is applied last and overrides every per-source bit
  wire [5:0] pin_int = wake_hit & ~pin_inh;
  wire src_evt = (sns_uv_evt & ~int_cfg_q[`INH_SNS_BIT]) |
                 (pre_evt & ~int_cfg_q[`INH_PRE_BIT]) |
                 (core_evt & ~int_cfg_q[`INH_CORE_BIT]) |
                 (others_evt & ~int_cfg_q[`INH_OTHERS_BIT]) |
                 (can_err_evt & ~int_cfg_q[`INH_CAN_BIT]);
  wire int_trig = ~int_cfg_q[`INH_ALL_BIT] & (src_evt | (|pin_int));
  wire int_n_w;

  int_pulse_gen u_pulse (
    .clk(clk),
    .srst(srst),
    .trigger(int_trig),
    .short_sel(int_cfg_q[`INT_DUR_BIT]),
    .int_n(int_n_w)
  );

  // outputs registered once more so every port comes from a flip-flop
  always @(posedge clk) begin
    if (srst) begin
      int_n <= 1'b1;
      io_group_flag <= 1'b0;
      wake_req <= 6'h00;
    end else begin
      int_n <= int_n_w;
      io_group_flag <= |(pin_wake_flag_q & ~pin_inh);
      wake_req <= wake_hit;
    end
  end
endmodule

// File: inc/io_wake_map.vh
/*
 Register addresses, field positions, reset values and timing counts for the
 pin wake and interrupt configuration bank. Assumes a 100 MHz system clock.
*/
`ifndef IO_WAKE_MAP_VH
`define IO_WAKE_MAP_VH

// 5-bit register addresses carried in frame bits 13..9
`define ADDR_WAKE_CFG_A 5'h04
`define ADDR_WAKE_CFG_B 5'h05
`define ADDR_INT_CFG 5'h06
`define ADDR_HW_REPORT 5'h08
`define ADDR_WAKE_SRC 5'h09
`define ADDR_PIN_LEVELS 5'h0B

// frame layout: bit15 write flag, 13..9 address, 8 parity, 7..0 data
`define FRAME_BITS 16
`define FRM_WRITE 15
`define FRM_ADDR_HI 13
`define FRM_ADDR_LO 9

// interrupt configuration fields
`define INT_DUR_BIT 7
`define INH_ALL_BIT 5
`define INH_SNS_BIT 4
`define INH_PRE_BIT 3
`define INH_CORE_BIT 2
`define INH_OTHERS_BIT 1
`define INH_CAN_BIT 0
`define INT_CFG_MASK 8'hBF

// wake edge encodings
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_ANY 2'h3

`define CFG_RESET 8'h00

// interrupt pulse widths in microseconds and cycles at 100 MHz
`define CLK_MHZ 100
`define INT_LONG_US 100
`define INT_SHORT_US 25
`define INT_LONG_CYC (`INT_LONG_US * `CLK_MHZ)
`define INT_SHORT_CYC (`INT_SHORT_US * `CLK_MHZ)

`endif

// File: hw/pin_sync2.v
/*
 Two flip-flop synchroniser, one per bit of a bus.
 Assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ns
module pin_sync2 #(
  parameter W = 1
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire [W-1:0] async_in, // foreign-domain levels
  output reg [W-1:0] sync_out // synchronised levels
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: hw/int_pulse_gen.v
/*
 Interrupt pulse stretcher: a trigger starts a low-active pulse of a long
 or short width. Assumes trigger is a one-cycle pulse on clk.
*/
`timescale 1ns/1ns
`include "io_wake_map.vh"
module int_pulse_gen #(
  parameter [13:0] LONG_CYC = `INT_LONG_CYC,
  parameter [13:0] SHORT_CYC = `INT_SHORT_CYC
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire trigger, // start a pulse
  input wire short_sel, // 1 selects short width
  output reg int_n // interrupt output, active low
);
  reg [13:0] cnt_q;

  // a trigger during a running pulse restarts the width
  always @(posedge clk) begin
    if (srst) begin
      cnt_q <= 14'h0000;
      int_n <= 1'b1;
    end else if (trigger) begin
      cnt_q <= (short_sel ? SHORT_CYC : LONG_CYC) - 14'h0001;
      int_n <= 1'b0;
    end else if (cnt_q != 14'h0000) begin
      cnt_q <= cnt_q - 14'h0001;
    end else begin
      int_n <= 1'b1;
    end
  end
endmodule

// File: sim/io_wake_bank_props.sv
/* port checks for the wake bank.
   assumes a 100 MHz clk and a slow sck. */
`timescale 1ns/1ns
`include "io_wake_map.vh"
module io_wake_bank_props (
  input wire clk, // clock
  input wire srst, // reset
  input wire sck, // spi clock
  input wire cs_n, // select
  input wire miso, // spi out
  input wire miso_oe, // out enable
  input wire second_feedback_monitor_en, // pin 1 taken
  input wire int_n, // interrupt
  input wire io_group_flag, // group flag
  input wire [5:0] wake_req // wake pulses
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  integer low_q;
  integer rise_q;
  reg sck_q;
  ////////////////////////////////
  // raw sck rising edges counted per frame; design lags, so bounds stay loose
  always @(posedge clk) begin
    sck_q <= sck;
    if (srst || int_n) low_q <= 0;
    else low_q <= low_q + 1;
    if (cs_n) rise_q <= 0;
    else if (sck && !sck_q) rise_q <= rise_q + 1;
  end
  a_reset_idle: assert property (disable iff (1'b0) srst |=> int_n && !miso_oe &&
    wake_req == 6'h00 && !io_group_flag) else $error("outputs busy after reset");
  a_int_width: assert property ($rose(int_n) && !$past(srst) |->
    low_q >= `INT_SHORT_CYC) else $error("interrupt pulse too short");
  a_miso_lead_zero: assert property (!cs_n && rise_q >= 2 && rise_q < 8 |-> !miso)
    else $error("miso high in command half");
  a_oe_off: assert property (cs_n [*5] |-> !miso_oe) else $error("miso driven idle");
  a_oe_on: assert property (!cs_n [*5] |-> miso_oe) else $error("miso not driven");
  a_pin1_blocked: assert property (second_feedback_monitor_en [*4] |-> !wake_req[1])
    else $error("pin 1 woke");
  a_wake_single: assert property (wake_req != 6'h00 |=>
    (wake_req & $past(wake_req)) == 6'h00) else $error("wake pulse too long");
  a_group_cause: assert property ($rose(io_group_flag) |-> wake_req != 6'h00 ||
    $past(wake_req) != 6'h00 || $past(wake_req, 2) != 6'h00 || $past(wake_req, 3) != 6'h00)
    else $error("group flag without wake");
  c_int: cover property ($rose(int_n));
  c_wake: cover property (wake_req != 6'h00);
  c_group: cover property ($rose(io_group_flag));
endmodule
bind io_wake_bank io_wake_bank_props chk_i (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
  .miso(miso), .miso_oe(miso_oe), .second_feedback_monitor_en(second_feedback_monitor_en),
  .int_n(int_n), .io_group_flag(io_group_flag), .wake_req(wake_req));

// File: sim/spi_host_model.sv
/* host model: mode 0 spi master, 16-bit frames, msb first.
   assumes miso is valid only while miso_oe is high. */
`timescale 1ns/1ns
module spi_host (
  output reg sck, // idle low between frames
  output reg cs_n, // select, active low
  output reg mosi, // data to device
  input wire miso, // data from device
  input wire miso_oe // device drive enable
);
  localparam HALF = 80;
  initial begin
    sck = 0;
    cs_n = 1;
    mosi = 0;
  end
  ////////////////////////////////
  task xfer(input [15:0] f, output [7:0] rd);
    integer i;
    begin
      cs_n = 0;
      for (i = 15; i >= 0; i = i - 1) begin
        mosi = f[i];
        #HALF sck = 1;
        if (i < 8) rd[i] = miso_oe ? miso : 1'bx;
        #HALF sck = 0;
      end
      // released line must not keep the last bit
      #HALF mosi = ~mosi;
      cs_n = 1;
      #HALF;
    end
  endtask
endmodule

// File: sim/io_wake_bank_test.sv
/* self-checking bench for the wake bank.
   assumes the spi host model and a 100 MHz clock. */
`timescale 1ns/1ns
`include "io_wake_map.vh"
module io_wake_bank_test;
  reg clk = 0, srst = 1, lp = 0, ini = 1, fb = 0, bw = 0;
  reg [5:0] pin = 0, strap = 0, s0;
  reg [4:0] ev = 0;
  reg [7:0] rd, cfg;
  wire sck, cs_n, mosi, miso, miso_oe, int_n, grp;
  wire [5:0] wreq;
  integer errors = 0, n_tests = 0, i, k, w, t;
  always #5 clk = ~clk;
  spi_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  io_wake_bank uut (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .io_pin(pin), .bus_wake_evt(bw),
    .low_power_off_state(lp), .init_phase(ini), .second_feedback_monitor_en(fb),
    .strap_in(strap), .sns_uv_evt(ev[4]), .pre_evt(ev[3]), .core_evt(ev[2]),
    .others_evt(ev[1]), .can_err_evt(ev[0]), .int_n(int_n), .io_group_flag(grp),
    .wake_req(wreq));
  ////////////////////////////////
  function [7:0] hw_exp(input [5:0] s);
    hw_exp = {s[5:1], 2'b10, s[0]};
  endfunction
  function [7:0] lvl_exp(input [5:0] p);
    lvl_exp = {p[5:4], 1'b0, p[3:2], 1'b0, p[1:0]};
  endfunction
  task complete_run;
    begin
      $display("mismatches %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        errors++;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task bound(input integer n);
    if (n >= 11000) begin
      errors++;
      complete_run;
    end
  endtask
  task rd_chk(input [4:0] a, input [7:0] exp);
    begin
      host.xfer({2'b00, a, 9'h000}, rd);
      chk(rd, exp);
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    host.xfer({2'b10, a, 1'b0, d}, rd);
  endtask
  // read clears flags first, so only this edge shows
  task toggle(input [5:0] p, input [7:0] exp, input b);
    begin
      host.xfer(16'h1200, rd);
      @(posedge clk) pin <= p;
      bw <= b;
      @(posedge clk) bw <= 0;
      repeat (8) @(posedge clk);
      rd_chk(5'h09, exp);
    end
  endtask
  task pulse_ev(input integer n, output integer width);
    begin
      for (t = 0; t < 11000 && int_n !== 1'b1; t++) @(negedge clk);
      bound(t);
      @(posedge clk) ev[n] <= 1;
      @(posedge clk) ev[n] <= 0;
      for (t = 0; t < 20 && int_n === 1'b1; t++) @(negedge clk);
      for (width = 0; int_n === 1'b0 && width < 11000; width++) @(negedge clk);
      bound(width);
    end
  endtask
  initial begin
    i = $urandom(32'hC363);
    strap = $urandom;
    s0 = strap;
    repeat (10) @(posedge clk);
    srst <= 0;
    pin <= $urandom;
    repeat (8) @(posedge clk);
    for (i = 4; i < 11; i++) if (i != 8) rd_chk(i[4:0], 8'h00);
    rd_chk(5'h08, hw_exp(s0));
    k = pin;
    rd_chk(5'h0B, lvl_exp(k[5:0]));
    @(posedge clk) lp <= 1;
    pin <= ~k[5:0];
    strap <= ~s0;
    repeat (8) @(posedge clk);
    rd_chk(5'h0B, lvl_exp(k[5:0]));
    @(posedge clk) lp <= 0;
    repeat (8) @(posedge clk);
    rd_chk(5'h0B, lvl_exp(~k[5:0]));
    rd_chk(5'h08, hw_exp(~s0));
    $display("levels and straps done");
    cfg = $urandom;
    wr(5'h06, cfg);
    rd_chk(5'h06, cfg & `INT_CFG_MASK);
    @(posedge clk) ini <= 0;
    repeat (4) @(posedge clk);
    wr(5'h06, ~cfg);
    wr(5'h08, 8'hFF);
    rd_chk(5'h06, cfg & `INT_CFG_MASK);
    rd_chk(5'h08, hw_exp(~s0));
    @(posedge clk) ini <= 1;
    pin <= 6'h00;
    repeat (4) @(posedge clk);
    $display("config access done");
    for (k = 0; k < 4; k++) begin
      cfg = {k[1:0], k[1:0], k[1:0], 2'b00};
      wr(5'h04, cfg);
      wr(5'h05, cfg);
      rd_chk(5'h05, cfg);
      toggle(6'h3F, k[0] ? 8'hFC : 8'h00, 0);
      toggle(6'h00, k[1] ? 8'hFC : 8'h00, 0);
    end
    @(posedge clk) fb <= 1;
    toggle(6'h3F, 8'hF4, 0);
    @(posedge clk) fb <= 0;
    toggle(6'h3F, 8'h01, 1);
    // pin 0 edge lands after the answer is taken but before the frame ends
    fork
      host.xfer(16'h1200, rd);
      begin
        repeat (200) @(posedge clk);
        pin <= 6'h3E;
      end
    join
    chk(rd, 8'h00);
    rd_chk(5'h09, 8'h04);
    $display("wake edges done");
    wr(5'h04, 8'hFD);
    wr(5'h05, 8'hFD);
    pulse_ev(0, w);
    host.xfer(16'h1200, rd);
    @(posedge clk) pin <= 6'h1E;
    repeat (8) @(posedge clk);
    chk(grp, 0);
    @(posedge clk) pin <= 6'h1A;
    repeat (8) @(posedge clk);
    chk(grp, 1);
    $display("pin inhibit done");
    for (k = 0; k < 5; k++) begin
      wr(5'h06, 8'h80 | (8'h01 << k));
      pulse_ev(k, w);
      chk(w == 0, 1);
      pulse_ev((k + 1) % 5, w);
      chk(w >= `INT_SHORT_CYC && w <= `INT_SHORT_CYC + 2, 1);
    end
    wr(5'h06, 8'hA0);
    pulse_ev(2, w);
    chk(w == 0, 1);
    wr(5'h06, 8'h00);
    pulse_ev(0, w);
    chk(w >= `INT_LONG_CYC && w <= `INT_LONG_CYC + 2, 1);
    $display("interrupt pulses done");
    complete_run;
  end
endmodule
